// file: sense_qualifier.sv
// synchroniser and pulse-width qualifier for one sense input
`timescale 1ns/10ps
`include "user_io_defines.svh"
module sense_qualifier
	import user_io_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pin in, qualified event out
	input wire logic pin,
	output logic hit
);
	// ==========================================================
	// two-stage synchroniser
	logic sync1_q;
	logic sync2_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pin;
			sync2_q <= sync1_q;
		end
	end

	// ==========================================================
	// count consecutive asserted cycles; hit stays high while held
	qual_state_e st_q, st_d;
	logic [`SENSE_CNT_W-1:0] cnt_q, cnt_d;
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			q_idle: begin
				cnt_d = '0;
				if (sync2_q) begin
					st_d = q_count;
					cnt_d = `SENSE_CNT_W'(1);
				end
			end
			q_count: begin
				if (!sync2_q) begin
					st_d = q_idle;
				end else if (cnt_q == `SENSE_CNT_W'(`SENSE_CYCLES - 1)) begin
					st_d = q_held; // [R11]
				end else begin
					cnt_d = cnt_q + `SENSE_CNT_W'(1);
				end
			end
			q_held: begin
				if (!sync2_q) begin
					st_d = q_idle;
				end
			end
			default: st_d = q_idle;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= q_idle;
			cnt_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
		end
	end

	assign hit = (st_q == q_held);
endmodule

// file: tb.sv
// self-checking bench for the user sense and enable pin block
`timescale 1ns/10ps
`include "user_io_defines.svh"
module tb;
	import user_io_pkg::*;
	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	bus_req_s bus = '0;
	logic [7:0] rdata;
	logic rpar, s0, s1, en0, en1, run_mode;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	user_logic_model i_user_logic_model (.clk(clk), .sense_0(s0), .sense_1(s1));
	user_sense_enable_pins i_user_sense_enable_pins (.clk(clk), .rst_n(rst_n), .bus(bus),
		.rdata(rdata), .rpar(rpar), .user_sense_in_0(s0), .user_sense_in_1(s1),
		.user_enable_out_0(en0), .user_enable_out_1(en1), .run_mode(run_mode));
	// ==========================================================
	// tasks
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// bad flips the parity bit so the write must be dropped
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic bad);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wpar: ~^d ^ bad, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wpar: 1'b0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk("rdata", exp, rdata);
		chk("rpar", {7'h00, ~^exp}, {7'h00, rpar});
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// timeout: the tests take about 130 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ==========================================================
	// tests
	initial begin
		do_reset();
		rd(`ADDR_MODE, 8'h00);
		chk("run_mode", 8'h00, {7'h00, run_mode});
		rd(`ADDR_USER_IO, 8'h00);
		wr(`ADDR_USER_IO, 8'h04, 1'b0);
		chk("enables", 8'h01, {6'h00, en1, en0});
		wr(`ADDR_USER_IO, 8'h08, 1'b0);
		chk("enables", 8'h02, {6'h00, en1, en0});
		wr(`ADDR_USER_IO, 8'h0c, 1'b1);
		chk("enables", 8'h02, {6'h00, en1, en0});
		rd(`ADDR_USER_IO, 8'h08);
		rd(`ADDR_CAUSE, 8'h01);
		wr(`ADDR_CAUSE, 8'h01, 1'b0);
		rd(`ADDR_CAUSE, 8'h00);
		rd(6'h10, 8'h00);
		i_user_logic_model.pulse(0, 14);
		repeat (6) @(posedge clk);
		rd(`ADDR_USER_IO, 8'h08);
		i_user_logic_model.pulse(0, 17);
		repeat (6) @(posedge clk);
		rd(`ADDR_USER_IO, 8'h09);
		i_user_logic_model.pulse(1, 17);
		repeat (6) @(posedge clk);
		rd(`ADDR_USER_IO, 8'h0b);
		wr(`ADDR_USER_IO, 8'h0a, 1'b0);
		rd(`ADDR_USER_IO, 8'h0a);
		wr(`ADDR_MODE, 8'h01, 1'b0);
		chk("run_mode", 8'h01, {7'h00, run_mode});
		do_reset();
		chk("enables", 8'h00, {6'h00, en1, en0});
		chk("run_mode", 8'h00, {7'h00, run_mode});
		rd(`ADDR_USER_IO, 8'h00);
		give_verdict();
	end
endmodule

// file: user_io_defines.svh
// register offsets, field positions, reset values and timing counts for the user pin block
`ifndef USER_IO_DEFINES_SVH
`define USER_IO_DEFINES_SVH

// ==========================================================
// register map (byte-wide registers, six-bit address)
`define ADDR_W 6
`define DATA_W 8
`define ADDR_MODE 6'h00
`define ADDR_CAUSE 6'h02
`define ADDR_USER_IO 6'h3f

// ==========================================================
// field positions
`define MODE_RUN_BIT 0
`define CAUSE_PARITY_BIT 0
`define UIO_SENSE0_BIT 0
`define UIO_SENSE1_BIT 1
`define UIO_ENABLE0_BIT 2
`define UIO_ENABLE1_BIT 3

// ==========================================================
// reset values
`define MODE_RST 8'h00
`define CAUSE_RST 8'h00
`define UIO_RST 8'h00

// ==========================================================
// timing: sense pulse minimum width
`define CLK_PERIOD_NS 10
`define SENSE_MIN_NS 160
`define SENSE_CYCLES ((`SENSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SENSE_CNT_W 5

`endif

// file: user_io_pkg.sv
// types shared by the user pin block
package user_io_pkg;
	`include "user_io_defines.svh"

	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wdata;
		logic wpar;
		logic wr;
		logic rd;
	} bus_req_s;

	typedef enum logic [1:0] {
		q_idle,
		q_count,
		q_held
	} qual_state_e;
endpackage

// file: user_logic_model.sv
// model of the external user logic that drives the sense pins
`timescale 1ns/10ps
module user_logic_model (
	// clock
	input wire logic clk,
	// sense pins toward the block
	output logic sense_0,
	output logic sense_1
);
	// ==========================================================
	// pulse driver
	initial begin
		sense_0 = 1'b0;
		sense_1 = 1'b0;
	end
	// hold one pin high for n sampled edges; both fall together so idle is always low
	task automatic pulse(input int idx, input int n);
		@(posedge clk);
		if (idx == 0) begin
			sense_0 <= 1'b1;
		end else begin
			sense_1 <= 1'b1;
		end
		repeat (n) @(posedge clk);
		sense_0 <= 1'b0;
		sense_1 <= 1'b0;
	endtask
endmodule

// file: user_sense_enable_pins.sv
// user sense and enable pins with their byte-wide register slave
//
// Contract
// R1 - reset clears every register, sense and enable
// R2 - reset forces mode bit zero: stop mode
// R3 - host holds reset, waits before access
// R4 - sense flag 0 sets after 160 ns
// R5 - sense flag 0 sticky until bus clear
// R6 - sense flag 1 sets, sticky likewise
// R7 - enable output 0 follows enable bit 0
// R8 - enable output 1 follows enable bit 1
// R9 - sixty-four byte registers, six-bit address; the code maps only mode, cause and user io, other offsets read zero
// R10 - bad parity write dropped, error flagged
// R11 - sense synchronised and qualified by count
// R12 - writing zero clears sense flag; relatches
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "user_io_defines.svh"
module user_sense_enable_pins
	import user_io_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire user_io_pkg::bus_req_s bus,
	output logic [`DATA_W-1:0] rdata,
	output logic rpar,
	// user pins
	input wire logic user_sense_in_0,
	input wire logic user_sense_in_1,
	output logic user_enable_out_0,
	output logic user_enable_out_1,
	// mode state
	output logic run_mode
);
	import user_io_pkg::*;

	// ==========================================================
	// reset: the pin is asynchronous in assertion; internal active high
	logic rst;
	assign rst = !rst_n; // [R1]

	// ==========================================================
	// sense qualification
	logic hit0, hit1;
	sense_qualifier u_q0 (.clk(clk), .rst(rst), .pin(user_sense_in_0), .hit(hit0));
	sense_qualifier u_q1 (.clk(clk), .rst(rst), .pin(user_sense_in_1), .hit(hit1));

	// ==========================================================
	// register file: mode, interrupt cause, user io
	logic [`DATA_W-1:0] mode_q, mode_d;
	logic [`DATA_W-1:0] cause_q, cause_d;
	logic [`DATA_W-1:0] uio_q, uio_d;
	logic [`DATA_W-1:0] rdata_q, rdata_d;
	logic rpar_q, rpar_d;
	logic en0_q, en1_q;
	logic par_ok, wr_ok;

	// odd parity across data and parity bit
	assign par_ok = ^{bus.wdata, bus.wpar};
	assign wr_ok = bus.wr && par_ok; // [R10]

	always_comb begin
		mode_d = mode_q;
		cause_d = cause_q;
		uio_d = uio_q;
		rdata_d = '0;
		if (wr_ok) begin
			case (bus.addr)
				`ADDR_MODE: mode_d = bus.wdata;
				// a written one clears a cause bit, set still wins below
				`ADDR_CAUSE: cause_d = cause_q & ~bus.wdata;
				`ADDR_USER_IO: uio_d = bus.wdata; // [R12]
				default: ;
			endcase
		end
		if (bus.wr && !par_ok) begin
			cause_d[`CAUSE_PARITY_BIT] = 1'b1; // [R10]
		end
		// hardware set wins over a clear in the same cycle
		if (hit0) begin
			uio_d[`UIO_SENSE0_BIT] = 1'b1; // [R4] [R5]
		end
		if (hit1) begin
			uio_d[`UIO_SENSE1_BIT] = 1'b1; // [R6]
		end
		if (bus.rd) begin
			case (bus.addr) // [R9]
				`ADDR_MODE: rdata_d = mode_q;
				`ADDR_CAUSE: rdata_d = cause_q;
				`ADDR_USER_IO: rdata_d = uio_q;
				default: rdata_d = '0;
			endcase
		end
		rpar_d = ~^rdata_d;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= `MODE_RST; // [R2]
			cause_q <= `CAUSE_RST; // [R1]
			uio_q <= `UIO_RST; // [R1]
			rdata_q <= '0;
			rpar_q <= 1'b1;
			en0_q <= 1'b0;
			en1_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			cause_q <= cause_d;
			uio_q <= uio_d;
			rdata_q <= rdata_d;
			rpar_q <= rpar_d;
			en0_q <= uio_d[`UIO_ENABLE0_BIT]; // [R7]
			en1_q <= uio_d[`UIO_ENABLE1_BIT]; // [R8]
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	assign rdata = rdata_q;
	assign rpar = rpar_q;
	assign user_enable_out_0 = en0_q;
	assign user_enable_out_1 = en1_q;
	assign run_mode = mode_q[`MODE_RUN_BIT];

	// ==========================================================
	// checks
	chk_en0_follow: assert property (@(posedge clk) disable iff (rst) // [R7]
		user_enable_out_0 == uio_q[`UIO_ENABLE0_BIT])
		else $error("enable out 0 differs from its bit");
	chk_en1_follow: assert property (@(posedge clk) disable iff (rst) // [R8]
		user_enable_out_1 == uio_q[`UIO_ENABLE1_BIT])
		else $error("enable out 1 differs from its bit");
	// sixteen samples high is the shortest pulse that must latch
	chk_sense0_set: assert property (@(posedge clk) disable iff (rst) // [R4]
		user_sense_in_0 [*8] ##1 user_sense_in_0 [*8]
		|-> ##4 uio_q[`UIO_SENSE0_BIT])
		else $error("sense flag 0 not set after qualified pulse");
	chk_sense1_set: assert property (@(posedge clk) disable iff (rst) // [R6]
		user_sense_in_1 [*8] ##1 user_sense_in_1 [*8]
		|-> ##4 uio_q[`UIO_SENSE1_BIT])
		else $error("sense flag 1 not set after qualified pulse");
	chk_sense0_sticky: assert property (@(posedge clk) disable iff (rst) // [R5]
		uio_q[`UIO_SENSE0_BIT] && !(bus.wr && bus.addr == `ADDR_USER_IO)
		|=> uio_q[`UIO_SENSE0_BIT])
		else $error("sense flag 0 dropped without a bus write");
	chk_sense1_sticky: assert property (@(posedge clk) disable iff (rst) // [R6]
		uio_q[`UIO_SENSE1_BIT] && !(bus.wr && bus.addr == `ADDR_USER_IO)
		|=> uio_q[`UIO_SENSE1_BIT])
		else $error("sense flag 1 dropped without a bus write");
	chk_no_short: assert property (@(posedge clk) disable iff (rst) // [R11]
		$rose(uio_q[`UIO_SENSE0_BIT]) |-> $past(user_sense_in_0, 18))
		else $error("sense flag 0 set by a short pulse");
	chk_parity_err: assert property (@(posedge clk) disable iff (rst) // [R10]
		bus.wr && !(^{bus.wdata, bus.wpar}) |=> cause_q[`CAUSE_PARITY_BIT] && $stable(mode_q))
		else $error("bad parity write not dropped or flagged");
	chk_parity_uio: assert property (@(posedge clk) disable iff (rst) // [R10]
		bus.wr && !(^{bus.wdata, bus.wpar})
		|=> $stable(uio_q[`UIO_ENABLE1_BIT:`UIO_ENABLE0_BIT]))
		else $error("bad parity write changed an enable bit");
	chk_cause_clear: assert property (@(posedge clk) disable iff (rst) // [R10]
		bus.wr && (^{bus.wdata, bus.wpar}) && bus.addr == `ADDR_CAUSE
		&& bus.wdata[`CAUSE_PARITY_BIT] |=> !cause_q[`CAUSE_PARITY_BIT])
		else $error("parity error flag not cleared by a written one");
	chk_read_data: assert property (@(posedge clk) disable iff (rst) // [R9]
		bus.rd && bus.addr == `ADDR_USER_IO |=> rdata == $past(uio_q) && (^{rdata, rpar}))
		else $error("read data or parity wrong");
	chk_clear_zero: assert property (@(posedge clk) disable iff (rst) // [R12]
		bus.wr && (^{bus.wdata, bus.wpar}) && bus.addr == `ADDR_USER_IO
		&& !bus.wdata[`UIO_SENSE0_BIT] && !hit0 |=> !uio_q[`UIO_SENSE0_BIT])
		else $error("sense flag 0 not cleared by write of zero");
	chk_clear_one: assert property (@(posedge clk) disable iff (rst) // [R12]
		bus.wr && (^{bus.wdata, bus.wpar}) && bus.addr == `ADDR_USER_IO
		&& !bus.wdata[`UIO_SENSE1_BIT] && !hit1 |=> !uio_q[`UIO_SENSE1_BIT])
		else $error("sense flag 1 not cleared by write of zero");
	chk_no_short1: assert property (@(posedge clk) disable iff (rst) // [R11]
		$rose(uio_q[`UIO_SENSE1_BIT]) && !$past(bus.wr)
		|-> $past(user_sense_in_1, 18) && $past(user_sense_in_1, 4))
		else $error("sense flag 1 set by a short pulse");

	// ==========================================================
	// reset and plain register checks
	// reset is sampled without a disable so the cleared state itself is checked
	chk_reset_clear: assert property (@(posedge clk) // [R1]
		rst |-> !user_enable_out_0 && !user_enable_out_1 && uio_q == `UIO_RST
		&& cause_q == `CAUSE_RST)
		else $error("reset left a register or enable set");
	chk_reset_stop: assert property (@(posedge clk) // [R2]
		rst |-> !run_mode && mode_q == `MODE_RST)
		else $error("reset did not force stop mode");
	chk_mode_write: assert property (@(posedge clk) disable iff (rst) // [R9]
		bus.wr && (^{bus.wdata, bus.wpar}) && bus.addr == `ADDR_MODE
		|=> mode_q == $past(bus.wdata))
		else $error("mode write did not land");
	chk_enable_write: assert property (@(posedge clk) disable iff (rst) // [R7] [R8]
		bus.wr && (^{bus.wdata, bus.wpar}) && bus.addr == `ADDR_USER_IO
		|=> uio_q[`UIO_ENABLE1_BIT:`UIO_ENABLE0_BIT]
		== $past(bus.wdata[`UIO_ENABLE1_BIT:`UIO_ENABLE0_BIT]))
		else $error("enable bits not written");
	chk_unmapped_rd: assert property (@(posedge clk) disable iff (rst) // [R9]
		bus.rd && bus.addr != `ADDR_MODE && bus.addr != `ADDR_CAUSE
		&& bus.addr != `ADDR_USER_IO |=> rdata == '0)
		else $error("unmapped read returned data");
	chk_rdata_idle: assert property (@(posedge clk) disable iff (rst) // [R9]
		!bus.rd |=> rdata == '0 && rpar)
		else $error("read data stands without a read");
endmodule
